// ---- vie_pkg.sv ----
// constants, encodings and register map of the virtual-interrupt extension unit
// assumes one 100 MHz clock and a 32-bit AXI4-Lite register bus
package vie_pkg;
  localparam int ADDR_W = 9;
  // byte offsets on the register bus
  localparam logic [8:0] OFS_CTRL  = 9'h000;
  localparam logic [8:0] OFS_FLAGS = 9'h004;
  localparam logic [8:0] OFS_IO_PERMISSION_BITMAP  = 9'h008;
  localparam logic [8:0] OFS_INSTR = 9'h00C;
  localparam logic [8:0] OFS_RES   = 9'h010;
  localparam logic [8:0] OFS_STACK = 9'h014;
  localparam logic [8:0] OFS_TSS   = 9'h100;
  // ctrl_reg_four and mode bits
  localparam int CTL_VME  = 0;
  localparam int CTL_PVI  = 1;
  localparam int CTL_V86  = 2;
  localparam int CTL_LONG = 3;
  localparam int CTL_CPL  = 4;
  // flags_register fields
  localparam int FLG_IF   = 9;
  localparam int FLG_IO_PRIV_LEVEL = 12;
  localparam int FLG_VIF  = 19;
  localparam int FLG_VIP  = 20;
  // instruction and result fields
  localparam int INS_VEC  = 8;
  localparam int RES_BUSY = 2;
  localparam int RES_VEC  = 8;
  localparam int RES_TGT  = 16;
  localparam logic [1:0] PRIV_USER = 2'h3;
  // task image and bitmap geometry
  localparam int TSS_WORDS = 64;
  localparam logic [7:0] RB_BYTES = 8'h20;
  // reset values
  localparam logic [31:0] RST_CTRL  = 32'h0000_0000;
  localparam logic [31:0] RST_FLAGS = 32'h0000_0002;
  localparam logic [31:0] RST_IO_PERMISSION_BITMAP  = 32'h0000_0080;
  localparam logic [1:0]  RESP_OK   = 2'h0;
  localparam logic [1:0]  RESP_ERR  = 2'h2;
  typedef enum logic [1:0] {
    OP_SET = 2'b00,
    OP_CLR = 2'b01,
    OP_SWI = 2'b10,
    OP_EXT = 2'b11
  } vie_op_e;
  typedef enum logic [1:0] {
    DSP_NONE  = 2'b00,
    DSP_FAULT = 2'b01,
    DSP_GATE  = 2'b10,
    DSP_V86   = 2'b11
  } vie_dsp_e;
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_EXEC  = 2'b01,
    ST_FETCH = 2'b10,
    ST_TEST  = 2'b11
  } vie_st_e;
endpackage

// ---- vie_tss_mem.sv ----
// byte-readable task image that holds the redirect bitmap
// assumes word writes from the bus slave and one registered byte read
`timescale 1ns/10ps
module vie_tss_mem
  import vie_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        wr_en,
  input  wire logic [5:0]  wr_word,
  input  wire logic [31:0] wr_data,
  input  wire logic [3:0]  wr_strb,
  input  wire logic [7:0]  rd_byte,
  output logic      [7:0]  rd_data
);
  logic [31:0] rd_word;
  // ----------------------------------------
  // storage, one generate lane per byte
  // ----------------------------------------
  // each lane owns its own array, so no word has two writers
  for (genvar b = 0; b < 4; b++) begin : g_lane
    logic [7:0] lane [TSS_WORDS];
    always_ff @(posedge clk) begin
      if (wr_en && wr_strb[b]) begin
        lane[wr_word] <= wr_data[8*b +: 8];
      end
    end
    assign rd_word[8*b +: 8] = lane[rd_byte[7:2]];
  end
  // ----------------------------------------
  // registered byte read
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rd_data <= 8'h00;
    end else begin
      rd_data <= rd_word[8*rd_byte[1:0] +: 8];
    end
  end
endmodule

// ---- vie_unit.sv ----
// virtual-interrupt extension unit with its AXI4-Lite register slave
// assumes software issues one instruction at a time through the instr register
// limitation: an instr write that lands while busy is dropped, not queued
`timescale 1ns/10ps
module vie_unit
  import vie_pkg::*;
(
  input  wire logic              CLK,
  input  wire logic              RSTN,
  input  wire logic [ADDR_W-1:0] S_AXI_AWADDR,
  input  wire logic              S_AXI_AWVALID,
  output logic                   S_AXI_AWREADY,
  input  wire logic [31:0]       S_AXI_WDATA,
  input  wire logic [3:0]        S_AXI_WSTRB,
  input  wire logic              S_AXI_WVALID,
  output logic                   S_AXI_WREADY,
  output logic [1:0]             S_AXI_BRESP,
  output logic                   S_AXI_BVALID,
  input  wire logic              S_AXI_BREADY,
  input  wire logic [ADDR_W-1:0] S_AXI_ARADDR,
  input  wire logic              S_AXI_ARVALID,
  output logic                   S_AXI_ARREADY,
  output logic [31:0]            S_AXI_RDATA,
  output logic [1:0]             S_AXI_RRESP,
  output logic                   S_AXI_RVALID,
  input  wire logic              S_AXI_RREADY,
  output logic                   GP_FAULT,
  output logic                   EXEC_DONE
);
  logic [ADDR_W-1:0] aw_addr;
  logic              aw_full;
  logic [31:0]       w_data;
  logic [3:0]        w_strb;
  logic              w_full;
  logic              wr_fire;
  logic              wr_hit;
  logic              rd_hit;
  logic [31:0]       rd_mux;
  logic [31:0]       ctrl;
  logic [31:0]       flags;
  logic [31:0]       io_permission_bitmap;
  logic [31:0]       stack_img;
  logic [31:0]       result;
  vie_st_e           state;
  vie_st_e           next_state;
  vie_op_e           cur_op;
  logic [7:0]        cur_vec;
  logic              go;
  logic              finish;
  logic              v86;
  logic              vme_on;
  logic              pvi_on;
  logic [1:0]        io_priv_level;
  logic [1:0]        current_priv_level;
  logic              need_lookup;
  logic              redirected;
  logic [7:0]        rb_byte;
  logic [7:0]        rb_data;
  vie_dsp_e          next_dsp;
  logic [31:0]       next_flags;

  // ----------------------------------------
  // byte-lane merge of a bus write
  // ----------------------------------------
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return r;
  endfunction

  // ----------------------------------------
  // write channels, taken in either order
  // ----------------------------------------
  assign wr_fire = aw_full && w_full && !S_AXI_BVALID;
  assign wr_hit  = (aw_addr == OFS_CTRL) || (aw_addr == OFS_FLAGS) ||
                   (aw_addr == OFS_IO_PERMISSION_BITMAP) || (aw_addr == OFS_INSTR) ||
                   (aw_addr[8] && aw_addr[1:0] == 2'h0);

  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      aw_full       <= 1'b0;
      aw_addr       <= '0;
      S_AXI_AWREADY <= 1'b1;
    end else if (S_AXI_AWVALID && S_AXI_AWREADY) begin
      aw_full       <= 1'b1;
      aw_addr       <= S_AXI_AWADDR;
      S_AXI_AWREADY <= 1'b0;
    end else if (wr_fire) begin
      aw_full       <= 1'b0;
      S_AXI_AWREADY <= 1'b1;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      w_full       <= 1'b0;
      w_data       <= 32'h0000_0000;
      w_strb       <= 4'h0;
      S_AXI_WREADY <= 1'b1;
    end else if (S_AXI_WVALID && S_AXI_WREADY) begin
      w_full       <= 1'b1;
      w_data       <= S_AXI_WDATA;
      w_strb       <= S_AXI_WSTRB;
      S_AXI_WREADY <= 1'b0;
    end else if (wr_fire) begin
      w_full       <= 1'b0;
      S_AXI_WREADY <= 1'b1;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP  <= RESP_OK;
    end else if (wr_fire) begin
      S_AXI_BVALID <= 1'b1;
      S_AXI_BRESP  <= wr_hit ? RESP_OK : RESP_ERR;
    end else if (S_AXI_BREADY) begin
      S_AXI_BVALID <= 1'b0;
    end
  end

  // ----------------------------------------
  // read channel, answer one cycle after address
  // ----------------------------------------
  always_comb begin
    rd_hit = 1'b1;
    unique case (S_AXI_ARADDR)
      OFS_CTRL:  rd_mux = ctrl;
      OFS_FLAGS: rd_mux = flags;
      OFS_IO_PERMISSION_BITMAP:  rd_mux = io_permission_bitmap;
      OFS_INSTR: rd_mux = 32'h0000_0000;
      OFS_RES:   rd_mux = result;
      OFS_STACK: rd_mux = stack_img;
      default: begin
        // task image is write-only here: its read port belongs to the lookup
        rd_mux = 32'h0000_0000;
        rd_hit = S_AXI_ARADDR[8] && S_AXI_ARADDR[1:0] == 2'h0;
      end
    endcase
  end

  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      S_AXI_ARREADY <= 1'b1;
      S_AXI_RVALID  <= 1'b0;
      S_AXI_RDATA   <= 32'h0000_0000;
      S_AXI_RRESP   <= RESP_OK;
    end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID  <= 1'b1;
      S_AXI_RDATA   <= rd_mux;
      S_AXI_RRESP   <= rd_hit ? RESP_OK : RESP_ERR;
    end else if (S_AXI_RVALID && S_AXI_RREADY) begin
      S_AXI_RVALID  <= 1'b0;
      S_AXI_ARREADY <= 1'b1;
    end
  end

  // ----------------------------------------
  // control and bitmap base registers
  // ----------------------------------------
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      ctrl <= RST_CTRL;
    end else if (wr_fire && aw_addr == OFS_CTRL) begin
      ctrl <= merge(ctrl, w_data, w_strb);
    end
  end

  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      io_permission_bitmap <= RST_IO_PERMISSION_BITMAP;
    end else if (wr_fire && aw_addr == OFS_IO_PERMISSION_BITMAP) begin
      // the base is 16 bits wide: the upper lanes are masked and never written
      io_permission_bitmap <= merge(io_permission_bitmap, w_data & 32'h0000_FFFF, {2'b00, w_strb[1:0]});
    end
  end

  // ----------------------------------------
  // mode decode
  // ----------------------------------------
  assign io_priv_level   = flags[FLG_IO_PRIV_LEVEL +: 2];
  assign current_priv_level    = ctrl[CTL_CPL +: 2];
  assign v86    = ctrl[CTL_V86] && !ctrl[CTL_LONG];
  assign vme_on = ctrl[CTL_VME] && v86;
  assign pvi_on = ctrl[CTL_PVI] && !v86 && current_priv_level == PRIV_USER;
  // only a v86 software interrupt with the extension on reads the bitmap
  assign need_lookup = (cur_op == OP_SWI) && vme_on;

  // ----------------------------------------
  // instruction sequencer
  // ----------------------------------------
  assign go     = wr_fire && aw_addr == OFS_INSTR && state == ST_IDLE;
  assign finish = (state == ST_EXEC && !need_lookup) || state == ST_TEST;

  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      cur_op  <= OP_SET;
      cur_vec <= 8'h00;
    end else if (go) begin
      cur_op  <= vie_op_e'(w_data[1:0]);
      cur_vec <= w_data[INS_VEC +: 8];
    end
  end

  always_comb begin
    next_state = state;
    unique case (state)
      ST_IDLE:  if (go) next_state = ST_EXEC;
      ST_EXEC:  next_state = need_lookup ? ST_FETCH : ST_IDLE;
      ST_FETCH: next_state = ST_TEST;
      ST_TEST:  next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // ----------------------------------------
  // redirect bitmap lookup
  // ----------------------------------------
  // the bitmap ends right below the io map base; byte index wraps in the image
  assign rb_byte = 8'(io_permission_bitmap[7:0] - RB_BYTES + {3'h0, cur_vec[7:3]});
  // without a lookup the vector behaves as if its bit were set
  assign redirected = (state != ST_TEST) || rb_data[cur_vec[2:0]];

  vie_tss_mem u_tss (
    .clk     (CLK),
    .rst_n   (RSTN),
    .wr_en   (wr_fire && aw_addr[8]),
    .wr_word (aw_addr[7:2]),
    .wr_data (w_data),
    .wr_strb (w_strb),
    .rd_byte (rb_byte),
    .rd_data (rb_data)
  );

  // ----------------------------------------
  // instruction effect
  // ----------------------------------------
  always_comb begin
    next_flags = flags;
    next_dsp   = DSP_NONE;
    unique case (cur_op)
      OP_SET, OP_CLR: begin
        if (v86) begin
          if (io_priv_level == PRIV_USER) begin
            next_flags[FLG_IF] = cur_op == OP_SET;
          end else if (vme_on && cur_op == OP_SET && flags[FLG_VIP]) begin
            next_dsp = DSP_FAULT;
          end else if (vme_on) begin
            next_flags[FLG_VIF] = cur_op == OP_SET;
          end else begin
            next_dsp = DSP_FAULT;
          end
        end else if (current_priv_level <= io_priv_level) begin
          next_flags[FLG_IF] = cur_op == OP_SET;
        end else if (pvi_on) begin
          next_flags[FLG_VIF] = cur_op == OP_SET;
        end else begin
          next_dsp = DSP_FAULT;
        end
      end
      OP_SWI: begin
        if (v86 && !redirected) begin
          next_dsp = DSP_V86;
        end else if (v86 && io_priv_level != PRIV_USER) begin
          next_dsp = DSP_FAULT;
        end else begin
          next_dsp = DSP_GATE;
          next_flags[FLG_IF]  = 1'b0;
          next_flags[FLG_VIF] = 1'b0;
        end
      end
      OP_EXT: begin
        // external events always go to system software
        next_dsp = DSP_GATE;
        next_flags[FLG_IF] = 1'b0;
      end
    endcase
  end

  // ----------------------------------------
  // flags, stacked image and result
  // ----------------------------------------
  // hardware update wins over a software write landing in the same cycle
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      flags <= RST_FLAGS;
    end else if (finish) begin
      flags <= next_flags;
    end else if (wr_fire && aw_addr == OFS_FLAGS) begin
      // system software owns the pending bit in the flags register
      flags <= merge(flags, w_data, w_strb);
    end
  end

  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      stack_img <= 32'h0000_0000;
    end else if (finish && next_dsp != DSP_NONE) begin
      stack_img <= flags;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      result <= 32'h0000_0000;
    end else if (go) begin
      result[RES_BUSY] <= 1'b1;
    end else if (finish) begin
      result[1:0]            <= next_dsp;
      result[RES_BUSY]       <= 1'b0;
      result[RES_VEC +: 8]   <= cur_vec;
      // v86 vector table sits at address 0, four bytes per entry
      result[RES_TGT +: 10]  <= {cur_vec, 2'h0};
    end
  end

  // ----------------------------------------
  // completion pulses
  // ----------------------------------------
  // both pulses come from flops so the core sees each for one full cycle
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      GP_FAULT  <= 1'b0;
      EXEC_DONE <= 1'b0;
    end else begin
      GP_FAULT  <= finish && next_dsp == DSP_FAULT;
      EXEC_DONE <= finish;
    end
  end
endmodule

// ---- vie_unit_asserts.sv ----
// concurrent checks on the bus handshakes and the completion pulses
// assumes it is bound to vie_unit, every port connected by name
`timescale 1ns/10ps
module vie_unit_asserts
  import vie_pkg::*;
(
  input wire logic              CLK,
  input wire logic              RSTN,
  input wire logic [ADDR_W-1:0] S_AXI_AWADDR,
  input wire logic              S_AXI_AWVALID,
  input wire logic              S_AXI_AWREADY,
  input wire logic [31:0]       S_AXI_WDATA,
  input wire logic [3:0]        S_AXI_WSTRB,
  input wire logic              S_AXI_WVALID,
  input wire logic              S_AXI_WREADY,
  input wire logic [1:0]        S_AXI_BRESP,
  input wire logic              S_AXI_BVALID,
  input wire logic              S_AXI_BREADY,
  input wire logic [ADDR_W-1:0] S_AXI_ARADDR,
  input wire logic              S_AXI_ARVALID,
  input wire logic              S_AXI_ARREADY,
  input wire logic [31:0]       S_AXI_RDATA,
  input wire logic [1:0]        S_AXI_RRESP,
  input wire logic              S_AXI_RVALID,
  input wire logic              S_AXI_RREADY,
  input wire logic              GP_FAULT,
  input wire logic              EXEC_DONE
);
  // -------------------------------------------------
  // one clock domain, so one default for all checks
  // -------------------------------------------------
  default clocking @(posedge CLK); endclocking
  default disable iff (!RSTN);
  aw_slot_busy_a: assert property (S_AXI_AWVALID && S_AXI_AWREADY |=> !S_AXI_AWREADY)
    else $error("address slot stayed open after a write address was taken");
  read_answer_a: assert property (S_AXI_ARVALID && S_AXI_ARREADY
    |=> S_AXI_RVALID && !S_AXI_ARREADY)
    else $error("read answer missing one cycle after the address");
  write_answer_a: assert property (S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY
    && !S_AXI_BVALID |-> ##[1:2] S_AXI_BVALID) else $error("write response late");
  bresp_stands_a: assert property (S_AXI_BVALID && !S_AXI_BREADY
    |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
    else $error("write response dropped before it was taken");
  rdata_stands_a: assert property (S_AXI_RVALID && !S_AXI_RREADY
    |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
    else $error("read data dropped before it was taken");
  b_release_a: assert property (S_AXI_BVALID && S_AXI_BREADY |=> !S_AXI_BVALID && S_AXI_AWREADY)
    else $error("write slot not reopened after the response");
  done_pulse_a: assert property (EXEC_DONE |=> !EXEC_DONE)
    else $error("completion pulse longer than one cycle");
  fault_with_done_a: assert property (GP_FAULT |-> EXEC_DONE)
    else $error("fault pulse without completion");
endmodule

// ---- vie_sw_model.sv ----
// system software side: a register bus master issuing one access at a time
// assumes the unit answers per the bus handshake; waits are bounded
`timescale 1ns/10ps
module vie_sw_model
  import vie_pkg::*;
(
  input  wire logic              clk,
  output logic      [ADDR_W-1:0] awaddr,
  output logic                   awvalid,
  input  wire logic              awready,
  output logic      [31:0]       wdata,
  output logic      [3:0]        wstrb,
  output logic                   wvalid,
  input  wire logic              wready,
  input  wire logic [1:0]        bresp,
  input  wire logic              bvalid,
  output logic                   bready,
  output logic      [ADDR_W-1:0] araddr,
  output logic                   arvalid,
  input  wire logic              arready,
  input  wire logic [31:0]       rdata,
  input  wire logic [1:0]        rresp,
  input  wire logic              rvalid,
  output logic                   rready
);
  bit timed_out = 1'b0;
  initial begin
    awaddr = '0;
    awvalid = 1'b0;
    wdata = '0;
    wstrb = 4'h0;
    wvalid = 1'b0;
    bready = 1'b0;
    araddr = '0;
    arvalid = 1'b0;
    rready = 1'b0;
  end
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d, output logic [1:0] resp);
    int n;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    resp = 2'h3;
    for (n = 0; n < 100; n++) begin
      @(posedge clk);
      // a released channel shows the inverse, not the last value
      if (awvalid && awready) begin
        awvalid <= 1'b0;
        awaddr  <= ~a;
      end
      if (wvalid && wready) begin
        wvalid <= 1'b0;
        wdata  <= ~d;
      end
      if (bvalid) begin
        resp = bresp;
        bready <= 1'b0;
        break;
      end
    end
    if (n == 100) timed_out = 1'b1;
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [31:0] d, output logic [1:0] resp);
    int n;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    d = '0;
    resp = 2'h3;
    for (n = 0; n < 100; n++) begin
      @(posedge clk);
      if (arvalid && arready) begin
        arvalid <= 1'b0;
        araddr  <= ~a;
      end
      if (rvalid) begin
        d = rdata;
        resp = rresp;
        rready <= 1'b0;
        break;
      end
    end
    if (n == 100) timed_out = 1'b1;
  endtask
endmodule

// ---- vie_unit_tb_top.sv ----
// self-checking bench: reset values first, then instruction table, then bus corner cases and reset
// assumes vie_sw_model as bus master and the checker bound below
`timescale 1ns/10ps
module vie_unit_tb_top;
  import vie_pkg::*;
  typedef struct {
    logic [31:0] ctrl;
    logic [31:0] flags;
    vie_op_e op;
    logic [7:0] vec;
    logic fault;
    vie_dsp_e dsp;
    logic [31:0] fexp;
  } vie_row_s;
  logic CLK = 1'b0;
  logic RSTN = 1'b0;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, gp_fault, exec_done;
  int mismatches = 0;
  int checked = 0;
  int done_cnt = 0;
  int fault_cnt = 0;
  // bitmap words from byte io_permission_bitmap-32; vector 0x21 and vector 255 redirected
  logic [31:0] bmap [8] = '{0, 2, 0, 0, 0, 0, 0, 32'h8000_0000};
  vie_row_s rows [17] = '{
    '{5, 2, OP_SET, 0, 0, DSP_NONE, 32'h0008_0002},
    '{5, 32'h0008_0002, OP_CLR, 0, 0, DSP_NONE, 2},
    '{5, 32'h0010_0002, OP_SET, 0, 1, DSP_FAULT, 32'h0010_0002},
    '{4, 2, OP_SET, 0, 1, DSP_FAULT, 2},
    '{4, 2, OP_SWI, 5, 1, DSP_FAULT, 2},
    '{4, 32'h3202, OP_SWI, 5, 0, DSP_GATE, 32'h3002},
    '{5, 32'h0008_0002, OP_SWI, 32, 0, DSP_V86, 32'h0008_0002},
    '{5, 2, OP_SWI, 0, 0, DSP_V86, 2},
    '{5, 2, OP_SWI, 33, 1, DSP_FAULT, 2},
    '{5, 32'h0008_3002, OP_SWI, 33, 0, DSP_GATE, 32'h3002},
    '{5, 2, OP_SWI, 255, 1, DSP_FAULT, 2},
    '{5, 32'h0008_0202, OP_EXT, 32, 0, DSP_GATE, 32'h0008_0002},
    '{32'h32, 2, OP_SET, 0, 0, DSP_NONE, 32'h0008_0002},
    '{32'h32, 32'h0008_0002, OP_CLR, 0, 0, DSP_NONE, 2},
    '{32'h33, 2, OP_SWI, 32, 0, DSP_GATE, 2},
    '{32'h0D, 32'h0010_0002, OP_SET, 0, 0, DSP_NONE, 32'h0010_0202},
    '{32'h3A, 2, OP_SET, 0, 0, DSP_NONE, 32'h0008_0002}
  };
  always #5 CLK = ~CLK;
  vie_unit u_vie_unit (
    .CLK(CLK), .RSTN(RSTN), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
    .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid),
    .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
    .GP_FAULT(gp_fault), .EXEC_DONE(exec_done)
  );
  vie_sw_model u_vie_sw_model (
    .clk(CLK), .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
    .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready)
  );
  // -------------------------------------------------
  // pulse counters; a missed pulse shows as a count gap
  // -------------------------------------------------
  always @(posedge CLK) begin
    if (exec_done === 1'b1) begin
      done_cnt++;
      fault_cnt += (gp_fault === 1'b1) ? 1 : 0;
    end
  end
  task automatic test_done();
    $display("mismatches %0d checked %0d", mismatches, checked);
    if (mismatches == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic guard();
    if (u_vie_sw_model.timed_out) begin
      mismatches++;
      test_done();
    end
  endtask
  task automatic bw(input logic [8:0] a, input logic [31:0] d, input logic [1:0] er);
    logic [1:0] r;
    u_vie_sw_model.wr(a, d, r);
    guard();
    check({30'h0, r}, {30'h0, er}, "write response");
  endtask
  task automatic rdv(input logic [8:0] a, output logic [31:0] d, input logic [1:0] er);
    logic [1:0] r;
    u_vie_sw_model.rd(a, d, r);
    guard();
    check({30'h0, r}, {30'h0, er}, "read response");
  endtask
  task automatic rdc(input logic [8:0] a, input logic [31:0] e, input logic [1:0] er);
    logic [31:0] d;
    rdv(a, d, er);
    check(d, e, "read data");
  endtask
  task automatic run(input vie_row_s r);
    int n;
    int d0;
    int f0;
    logic [31:0] d;
    bw(OFS_CTRL, r.ctrl, RESP_OK);
    bw(OFS_FLAGS, r.flags, RESP_OK);
    d0 = done_cnt;
    f0 = fault_cnt;
    bw(OFS_INSTR, {16'h0, r.vec, 6'h0, r.op}, RESP_OK);
    for (n = 0; n < 50 && done_cnt == d0; n++) @(posedge CLK);
    if (n == 50) begin
      mismatches++;
      test_done();
    end
    check(32'(fault_cnt - f0), {31'h0, r.fault}, "fault pulse");
    rdv(OFS_RES, d, RESP_OK);
    check(d & 32'h7, {30'h0, r.dsp}, "dispatch");
    if (r.dsp == DSP_V86) check({22'h0, d[25:16]}, {22'h0, r.vec, 2'h0}, "table");
    rdc(OFS_FLAGS, r.fexp, RESP_OK);
  endtask
  initial begin
    repeat (20) @(posedge CLK);
    RSTN <= 1'b1;
    rdc(OFS_CTRL, RST_CTRL, RESP_OK);
    rdc(OFS_FLAGS, RST_FLAGS, RESP_OK);
    rdc(OFS_IO_PERMISSION_BITMAP, RST_IO_PERMISSION_BITMAP, RESP_OK);
    for (int k = 0; k < 8; k++) bw(OFS_TSS + 9'h060 + 9'(4 * k), bmap[k], RESP_OK);
    for (int i = 0; i < 17; i++) run(rows[i]);
    // -------------------------------------------------
    // hand cases: pending retry, stack image, bus refusals
    // -------------------------------------------------
    run(rows[2]);
    run(rows[0]);
    run(rows[9]);
    rdc(OFS_STACK, 32'h0008_3002, RESP_OK);
    bw(9'h018, 32'h1234_5678, RESP_ERR);
    rdc(9'h018, 32'h0, RESP_ERR);
    rdc(9'h164, 32'h0, RESP_OK);
    @(posedge CLK);
    RSTN <= 1'b0;
    repeat (2) @(posedge CLK);
    RSTN <= 1'b1;
    rdc(OFS_CTRL, RST_CTRL, RESP_OK);
    rdc(OFS_FLAGS, RST_FLAGS, RESP_OK);
    test_done();
  end
endmodule
bind vie_unit vie_unit_asserts u_vie_unit_asserts (
  .CLK(CLK), .RSTN(RSTN), .S_AXI_AWADDR(S_AXI_AWADDR), .S_AXI_AWVALID(S_AXI_AWVALID),
  .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WDATA(S_AXI_WDATA), .S_AXI_WSTRB(S_AXI_WSTRB),
  .S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BRESP(S_AXI_BRESP),
  .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY), .S_AXI_ARADDR(S_AXI_ARADDR),
  .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RDATA(S_AXI_RDATA),
  .S_AXI_RRESP(S_AXI_RRESP), .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY),
  .GP_FAULT(GP_FAULT), .EXEC_DONE(EXEC_DONE)
);
